// *** hw/seq_pkg.sv ***
// constants and types shared by the safety sequencer
package seq_pkg;
    typedef enum logic [2:0] {
        st_init,
        st_diag,
        st_protect,
        st_dispose,
        st_arming
    } seq_state_t;

    typedef enum logic [2:0] {
        cmd_none,
        cmd_protect_entry,
        cmd_dispose_entry,
        cmd_arm_request,
        cmd_arm_confirm,
        cmd_disposal_key
    } seq_cmd_t;

    typedef enum logic [2:0] {
        tst_none,
        tst_hs_squib,
        tst_ls_squib,
        tst_hs_safing,
        tst_arm_stuck,
        tst_fire_time
    } test_kind_t;

    localparam int key_width = 16;
    localparam logic [15:0] key_default = 16'hA5C3;
    localparam int key_timeout_us = 100;
    localparam int clk_mhz = 200;
    localparam int key_timeout_cycles = key_timeout_us * clk_mhz;
    localparam int handshake_window_cycles = 256;
    localparam int arm_count = 4;
endpackage : seq_pkg

// *** hw/seq_if.sv ***
// sequencer to test-arbiter signals
`timescale 1ns/100ps
interface seq_if;
    import seq_pkg::*;
    logic diag_active;
    logic flush;
    test_kind_t req_kind;
    logic req_valid;
    logic test_done;
    logic busy;
    test_kind_t run_kind;
    logic accepted;
    logic discarded;
    modport seq (output diag_active, flush, req_kind, req_valid, test_done,
        input busy, run_kind, accepted, discarded);
    modport arb (input diag_active, flush, req_kind, req_valid, test_done,
        output busy, run_kind, accepted, discarded);
endinterface : seq_if

// *** hw/test_arbiter.sv ***
// single-slot arbiter for diagnostic-state tests
`timescale 1ns/100ps
module test_arbiter
    import seq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    seq_if.arb link
);
    logic busy;
    test_kind_t run_kind;
    logic accepted;
    logic discarded;
    logic next_busy;
    test_kind_t next_run_kind;
    logic next_accepted;
    logic next_discarded;

    function automatic logic is_switch_test(input test_kind_t k);
        is_switch_test = (k == tst_hs_squib) || (k == tst_ls_squib)
            || (k == tst_hs_safing);
    endfunction : is_switch_test

    always_comb
    begin
        next_busy = busy;
        next_run_kind = run_kind;
        next_accepted = 1'b0;
        next_discarded = 1'b0;
        if (link.flush || !link.diag_active)
        begin
            next_busy = 1'b0;
            next_run_kind = tst_none;
        end
        else if (busy && link.test_done)
        begin
            next_busy = 1'b0;
            next_run_kind = tst_none;
        end
        if (link.req_valid && link.req_kind != tst_none)
        begin
            if (!link.diag_active || link.flush)
                next_discarded = 1'b1;
            else if (busy)
                next_discarded = 1'b1;
            else
            begin
                next_busy = 1'b1;
                next_run_kind = link.req_kind;
                next_accepted = 1'b1;
            end
        end
        if (!link.diag_active && is_switch_test(link.req_kind)
            && link.req_valid)
            next_discarded = 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            run_kind <= tst_none;
            accepted <= 1'b0;
            discarded <= 1'b0;
        end
        else
        begin
            busy <= next_busy;
            run_kind <= next_run_kind;
            accepted <= next_accepted;
            discarded <= next_discarded;
        end
    end

    assign link.busy = busy;
    assign link.run_kind = run_kind;
    assign link.accepted = accepted;
    assign link.discarded = discarded;
endmodule : test_arbiter

// *** hw/safety_sequencer.sv ***
// operating-state sequencer with arming handshake and test gating
`timescale 1ns/100ps
module safety_sequencer
    import seq_pkg::*;
#(
    parameter int timeout_cycles = key_timeout_cycles,
    parameter logic [15:0] disposal_key = key_default,
    parameter int n_arm = arm_count
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic supply_good,
    input wire logic sequencer_clear,
    input wire logic wd_service_ok,
    input wire logic cmd_valid,
    input wire seq_cmd_t cmd,
    input wire logic [15:0] cmd_key,
    input wire logic wd_window_wr,
    input wire logic config_wr,
    input wire logic test_req,
    input wire test_kind_t test_kind,
    input wire logic test_done,
    input wire logic protect_fire,
    input wire logic [n_arm-1:0] arm_pin_sense,
    input wire logic fire_time_ok,
    output logic reset_out_n,
    output seq_state_t state,
    output logic [n_arm-1:0] arm_output_n,
    output logic wd_window_wr_en,
    output logic config_wr_en,
    output logic sensor_monitor_en,
    output logic safing_logic_en,
    output logic test_busy,
    output test_kind_t test_running,
    output logic test_accepted,
    output logic test_discarded,
    output logic arm_stuck_fault,
    output logic fire_time_fault
);
    seq_if link ();

    test_arbiter u_arb (
        .mclk(mclk),
        .rst(rst),
        .link(link)
    );

    seq_state_t next_state;
    logic running;
    logic next_running;
    logic [31:0] key_timer;
    logic [31:0] next_key_timer;
    logic arm_pending;
    logic next_arm_pending;
    logic [8:0] hs_timer;
    logic [8:0] next_hs_timer;
    logic [n_arm-1:0] next_arm_output_n;
    logic next_reset_out_n;
    logic next_wd_window_wr_en;
    logic next_config_wr_en;
    logic next_sensor_monitor_en;
    logic next_safing_logic_en;
    logic next_arm_stuck_fault;
    logic next_fire_time_fault;
    logic [n_arm-1:0] pin_mismatch;

    function automatic logic cmd_is(input logic v, input seq_cmd_t c,
        input seq_cmd_t want);
        cmd_is = v && (c == want);
    endfunction : cmd_is

    // key compare shared by the confirm and the keep-alive commands
    function automatic logic key_ok(input logic [15:0] k);
        key_ok = (k == disposal_key);
    endfunction : key_ok

    // arming handshake: a request opens a window that only a confirm can use
    always_comb
    begin
        next_arm_pending = arm_pending;
        next_hs_timer = hs_timer;
        if (!running || sequencer_clear || state != st_dispose)
        begin
            next_arm_pending = 1'b0;
            next_hs_timer = 9'h000;
        end
        else if (cmd_is(cmd_valid, cmd, cmd_arm_request))
        begin
            next_arm_pending = 1'b1;
            next_hs_timer = 9'(handshake_window_cycles - 1);
        end
        else if (cmd_is(cmd_valid, cmd, cmd_arm_confirm))
            next_arm_pending = 1'b0;
        else if (arm_pending)
        begin
            // window closes unused once the count runs out
            if (hs_timer == 9'h000)
                next_arm_pending = 1'b0;
            else
                next_hs_timer = hs_timer - 9'h001;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            arm_pending <= 1'b0;
            hs_timer <= 9'h000;
        end
        else
        begin
            arm_pending <= next_arm_pending;
            hs_timer <= next_hs_timer;
        end
    end

    always_comb
    begin
        next_state = state;
        next_running = running;
        next_key_timer = key_timer;
        next_reset_out_n = supply_good;
        if (!running)
        begin
            // init is held, arm pins safe, until the supply first comes good
            next_state = st_init;
            next_running = supply_good;
        end
        else if (sequencer_clear)
        begin
            next_state = st_init;
        end
        else
        begin
            unique case (state)
                st_init:
                    if (wd_service_ok)
                        next_state = st_diag;
                st_diag:
                    if (cmd_is(cmd_valid, cmd, cmd_protect_entry))
                        next_state = st_protect;
                    else if (cmd_is(cmd_valid, cmd, cmd_dispose_entry))
                        next_state = st_dispose;
                st_protect:
                    // no command leaves protection
                    next_state = st_protect;
                st_dispose:
                    // a confirm with no open request, or a bad key, is dropped
                    if (arm_pending
                        && cmd_is(cmd_valid, cmd, cmd_arm_confirm)
                        && key_ok(cmd_key))
                    begin
                        next_state = st_arming;
                        next_key_timer = 32'(timeout_cycles);
                    end
                st_arming:
                    // every good key restarts the timer; one bad key ends it
                    if (cmd_is(cmd_valid, cmd, cmd_disposal_key))
                    begin
                        if (key_ok(cmd_key))
                            next_key_timer = 32'(timeout_cycles);
                        else
                            next_state = st_dispose;
                    end
                    else if (key_timer == 32'h0)
                        next_state = st_dispose;
                    else
                        next_key_timer = key_timer - 32'h1;
                default:
                    next_state = st_init;
            endcase
        end
    end

    // outputs follow the next state so every gate lines up with it
    always_comb
    begin
        next_wd_window_wr_en = (next_state == st_init) && next_running;
        next_config_wr_en = (next_state == st_init)
            || (next_state == st_diag);
        next_sensor_monitor_en = (next_state != st_dispose)
            && (next_state != st_arming);
        next_safing_logic_en = next_sensor_monitor_en;
        next_arm_output_n = {n_arm{1'b1}};
        if (next_state == st_arming)
            next_arm_output_n = {n_arm{1'b0}};
        else if (next_state == st_protect && protect_fire)
            next_arm_output_n = {n_arm{1'b0}};
        next_arm_stuck_fault = arm_stuck_fault;
        next_fire_time_fault = fire_time_fault;
        if (sequencer_clear)
        begin
            next_arm_output_n = {n_arm{1'b1}};
            next_arm_stuck_fault = 1'b0;
            next_fire_time_fault = 1'b0;
        end
        // a fault seen in the clearing cycle still latches: set wins
        if (link.test_done)
        begin
            if (link.run_kind == tst_arm_stuck && |pin_mismatch)
                next_arm_stuck_fault = 1'b1;
            if (link.run_kind == tst_fire_time && !fire_time_ok)
                next_fire_time_fault = 1'b1;
        end
    end

    // lane by lane readback of each arming pin against its driven level
    generate
        for (genvar i = 0; i < n_arm; i++)
        begin : g_pin
            assign pin_mismatch[i] = arm_pin_sense[i] != arm_output_n[i];
        end
    endgenerate

    // arbiter sees the diag state, the clear and the raw test strobes
    always_comb
    begin
        link.diag_active = (state == st_diag);
        link.flush = sequencer_clear;
        link.req_kind = test_kind;
        link.req_valid = test_req;
        link.test_done = test_done;
    end

    // state group: sequencer state, key timer and external reset
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state <= st_init;
            running <= 1'b0;
            key_timer <= 32'h0;
            reset_out_n <= 1'b0;
        end
        else
        begin
            state <= next_state;
            running <= next_running;
            key_timer <= next_key_timer;
            reset_out_n <= next_reset_out_n;
        end
    end

    // output group: arm pins, write and monitor gates, faults
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            arm_output_n <= {n_arm{1'b1}};
            wd_window_wr_en <= 1'b0;
            config_wr_en <= 1'b0;
            sensor_monitor_en <= 1'b0;
            safing_logic_en <= 1'b0;
            arm_stuck_fault <= 1'b0;
            fire_time_fault <= 1'b0;
        end
        else
        begin
            arm_output_n <= next_arm_output_n;
            wd_window_wr_en <= next_wd_window_wr_en;
            config_wr_en <= next_config_wr_en;
            sensor_monitor_en <= next_sensor_monitor_en;
            safing_logic_en <= next_safing_logic_en;
            arm_stuck_fault <= next_arm_stuck_fault;
            fire_time_fault <= next_fire_time_fault;
        end
    end

    // arbiter outputs are already registered inside the arbiter
    assign test_busy = link.busy;
    assign test_running = link.run_kind;
    assign test_accepted = link.accepted;
    assign test_discarded = link.discarded;
endmodule : safety_sequencer

// *** bench/seq_monitor.sv ***
// port assertions for the safety sequencer
`timescale 1ns/100ps
module seq_monitor
    import seq_pkg::*;
#(
    parameter int n_arm = arm_count
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic supply_good,
    input wire logic sequencer_clear,
    input wire logic cmd_valid,
    input wire logic reset_out_n,
    input wire seq_state_t state,
    input wire logic [n_arm-1:0] arm_output_n,
    input wire logic wd_window_wr_en,
    input wire logic sensor_monitor_en,
    input wire logic safing_logic_en
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    AST_RST_OUT: assert property (!supply_good |=> !reset_out_n)
        else $error("reset out released early");
    AST_WD_EN: assert property (wd_window_wr_en |-> state == st_init)
        else $error("window write open outside init");
    AST_DIAG_HOLD: assert property (state == st_diag && !cmd_valid
        && !sequencer_clear |=> state == st_diag)
        else $error("diag left without command");
    AST_PROT_HOLD: assert property (state == st_protect
        && !sequencer_clear |=> state == st_protect)
        else $error("protection left without clear");
    AST_DISP_EXIT: assert property (state == st_dispose |=>
        state inside {st_dispose, st_arming, st_init})
        else $error("bad exit from disposal");
    AST_ARM_ON: assert property (state == st_arming |-> ~|arm_output_n)
        else $error("arm outputs off in arming");
    AST_ARM_OFF: assert property (state inside {st_init, st_dispose}
        |-> &arm_output_n)
        else $error("arm outputs on outside arming");
    AST_MON_OFF: assert property (state inside {st_dispose, st_arming}
        |-> !sensor_monitor_en && !safing_logic_en)
        else $error("monitors on in disposal");
    cover property (state == st_arming);
    cover property (state == st_protect);
    cover property (state == st_arming ##1 state == st_dispose);
endmodule : seq_monitor

// *** bench/mcu_model.sv ***
// controller model issuing commands and watchdog services
`timescale 1ns/100ps
module mcu_model
    import seq_pkg::*;
(
    input wire logic mclk,
    output logic cmd_valid,
    output seq_cmd_t cmd,
    output logic [15:0] cmd_key,
    output logic wd_service_ok
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd = cmd_none;
        cmd_key = 16'h0000;
        wd_service_ok = 1'b0;
    end
    // one-cycle command; key flips after so a stale key never matches
    task send(input seq_cmd_t c, input logic [15:0] k);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd = c;
        cmd_key = k;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd = cmd_none;
        cmd_key = ~k;
    endtask : send
    task feed;
        @(negedge mclk);
        wd_service_ok = 1'b1;
        @(negedge mclk);
        wd_service_ok = 1'b0;
    endtask : feed
endmodule : mcu_model

// *** bench/safety_sequencer_test.sv ***
// self-checking bench for the safety sequencer
`timescale 1ns/100ps
module safety_sequencer_test;
    import seq_pkg::*;
    localparam int t_out = 20;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic supply_good = 1'b0;
    logic sequencer_clear = 1'b0;
    logic test_req = 1'b0;
    test_kind_t test_kind = tst_none;
    logic tst_end = 1'b0;
    logic stuck_inj = 1'b0;
    logic fire_ok = 1'b1;
    logic fire = 1'b0;
    test_kind_t run;
    logic cmd_valid, wd_ok, reset_out_n, wd_en, cfg_en, sens_en, saf_en;
    logic busy, acc, dis, stuck, ftf;
    seq_cmd_t cmd;
    logic [15:0] cmd_key;
    seq_state_t state;
    logic [3:0] arm_output_n;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    always #2.5 mclk = ~mclk;
    mcu_model u (.mclk(mclk), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_key(cmd_key), .wd_service_ok(wd_ok));
    safety_sequencer #(.timeout_cycles(t_out)) DUT (.mclk(mclk), .rst(rst),
        .supply_good(supply_good), .sequencer_clear(sequencer_clear),
        .wd_service_ok(wd_ok), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_key(cmd_key), .wd_window_wr(1'b0), .config_wr(1'b0),
        .test_req(test_req), .test_kind(test_kind), .test_done(tst_end),
        .protect_fire(fire),
        .arm_pin_sense(arm_output_n ^ {3'h0, stuck_inj}),
        .fire_time_ok(fire_ok), .reset_out_n(reset_out_n), .state(state),
        .arm_output_n(arm_output_n), .wd_window_wr_en(wd_en),
        .config_wr_en(cfg_en), .sensor_monitor_en(sens_en),
        .safing_logic_en(saf_en), .test_busy(busy), .test_running(run),
        .test_accepted(acc), .test_discarded(dis),
        .arm_stuck_fault(stuck), .fire_time_fault(ftf));
    task chk(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t: flag %b not %b", $time, got, exp);
        end
    endtask : chk
    task chk_st(input seq_state_t exp);
        n_compared++;
        if (state !== exp)
        begin
            failures++;
            $display("Error %0t: state %0d not %0d", $time, state, exp);
        end
    endtask : chk_st
    task step(input int n);
        repeat (n) @(negedge mclk);
    endtask : step
    task pulse_end;
        @(negedge mclk);
        tst_end = 1'b1;
        @(negedge mclk);
        tst_end = 1'b0;
    endtask : pulse_end
    // ends any running test so the next request finds the slot free
    task wait_idle;
        for (int i = 0; i < 20 && busy !== 1'b0; i++)
            pulse_end();
    endtask : wait_idle
    task try_test(input test_kind_t k, input logic exp);
        logic a, d;
        a = 1'b0;
        d = 1'b0;
        @(negedge mclk);
        test_req = 1'b1;
        test_kind = k;
        repeat (3)
        begin
            @(negedge mclk);
            test_req = 1'b0;
            a = a | acc;
            d = d | dis;
        end
        chk(a, exp);
        chk(d, !exp);
    endtask : try_test
    task clr;
        @(negedge mclk);
        sequencer_clear = 1'b1;
        @(negedge mclk);
        sequencer_clear = 1'b0;
        step(1);
    endtask : clr
    task arm(input logic [15:0] k);
        u.send(cmd_arm_request, 16'h0000);
        u.send(cmd_arm_confirm, k);
        step(1);
    endtask : arm
    task sc_start;
        chk(reset_out_n, 1'b0);
        chk_st(st_init);
        supply_good = 1'b1;
        step(3);
        chk(reset_out_n, 1'b1);
        chk(wd_en, 1'b1);
        u.send(cmd_protect_entry, 16'h0000);
        chk_st(st_init);
        try_test(tst_hs_squib, 1'b0);
        u.feed();
        step(1);
        chk_st(st_diag);
        chk(wd_en, 1'b0);
        chk(cfg_en, 1'b1);
    endtask : sc_start
    task sc_diag;
        wait_idle();
        try_test(tst_ls_squib, 1'b1);
        chk(run == tst_ls_squib, 1'b1);
        try_test(tst_hs_safing, 1'b0);
        wait_idle();
        try_test(tst_hs_safing, 1'b1);
        wait_idle();
        u.send(cmd_arm_request, 16'h0000);
        chk_st(st_diag);
        chk(stuck, 1'b0);
        chk(ftf, 1'b0);
        try_test(tst_arm_stuck, 1'b1);
        stuck_inj = 1'b1;
        pulse_end();
        stuck_inj = 1'b0;
        chk(stuck, 1'b1);
        try_test(tst_fire_time, 1'b1);
        fire_ok = 1'b0;
        pulse_end();
        fire_ok = 1'b1;
        chk(ftf, 1'b1);
    endtask : sc_diag
    task sc_dispose;
        u.send(cmd_dispose_entry, 16'h0000);
        step(1);
        chk_st(st_dispose);
        chk(sens_en | saf_en, 1'b0);
        try_test(tst_hs_squib, 1'b0);
        u.send(cmd_arm_confirm, key_default);
        chk_st(st_dispose);
        arm(16'h1234);
        chk_st(st_dispose);
        arm(key_default);
        chk_st(st_arming);
        chk(~|arm_output_n, 1'b1);
        repeat (3)
        begin
            step(t_out / 2);
            u.send(cmd_disposal_key, key_default);
        end
        chk_st(st_arming);
        u.send(cmd_disposal_key, 16'h0F0F);
        step(1);
        chk_st(st_dispose);
        arm(key_default);
        step(t_out + 10);
        chk_st(st_dispose);
        arm(key_default);
        clr();
        chk_st(st_init);
        chk(&arm_output_n, 1'b1);
        chk(stuck | ftf, 1'b0);
    endtask : sc_dispose
    task sc_protect;
        u.feed();
        u.send(cmd_protect_entry, 16'h0000);
        step(1);
        chk_st(st_protect);
        chk(sens_en, 1'b1);
        fire = 1'b1;
        step(1);
        chk(~|arm_output_n, 1'b1);
        fire = 1'b0;
        step(1);
        chk(&arm_output_n, 1'b1);
        u.send(cmd_dispose_entry, 16'h0000);
        u.send(cmd_arm_request, 16'h0000);
        step(1);
        chk_st(st_protect);
        clr();
        chk_st(st_init);
    endtask : sc_protect
    task test_done;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            test_done();
        end
    end
    initial
    begin
        step(5);
        rst = 1'b0;
        step(2);
        sc_start();
        sc_diag();
        sc_dispose();
        sc_protect();
        test_done();
    end
endmodule : safety_sequencer_test
bind safety_sequencer seq_monitor #(.n_arm(n_arm)) mon (.mclk(mclk),
    .rst(rst), .supply_good(supply_good),
    .sequencer_clear(sequencer_clear), .cmd_valid(cmd_valid),
    .reset_out_n(reset_out_n), .state(state),
    .arm_output_n(arm_output_n), .wd_window_wr_en(wd_window_wr_en),
    .sensor_monitor_en(sensor_monitor_en),
    .safing_logic_en(safing_logic_en));
